// [rtl/bkg_consts.svh]
// constants for the backup-mode bus gating block
// assumes inclusion by bare name from rtl files
`ifndef BKG_CONSTS_SVH
`define BKG_CONSTS_SVH
`define BKG_SYNC_STAGES 2
`define BKG_MODE_A 2'h0
`define BKG_MODE_B 2'h1
`define BKG_MODE_C 2'h2
`define BKG_MODE_D 2'h3
`define BKG_RST_BUS_DIS 1'h1
`define BKG_RST_DIS_BIT 1'h0
`define BKG_RST_SW_SEL 1'h1
`endif

// [rtl/bkg_pkg.sv]
// types for the backup-mode bus gating block
// assumes bkg_consts.svh holds the numeric constants
package bkg_pkg;
    typedef enum logic [1:0] {
        BKG_MODE_A_E,
        BKG_MODE_B_E,
        BKG_MODE_C_E,
        BKG_MODE_D_E
    } bkg_mode_t;
    typedef enum logic [1:0] {
        BKG_ON_MAIN,
        BKG_ON_BACKUP,
        BKG_IN_RESET
    } bkg_state_t;
endpackage : bkg_pkg

// [rtl/bkg_sync.sv]
// two-flop level synchroniser for a vector of comparator results
// assumes async inputs and one clock
`timescale 1ns/1ps
module bkg_sync #(
    parameter int WIDTH = 3
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bkg_sync_st_t;
    bkg_sync_st_t st_ff;
    bkg_sync_st_t nxt_st;
    always_comb begin
        nxt_st.meta = async_i;
        nxt_st.stable = st_ff.meta;
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign sync_o = st_ff.stable;
endmodule : bkg_sync

// [rtl/bkg_gate.sv]
// Summary of operation
// - below the reset threshold the serial interface is always off.
// - bus-disable bit and switchover-select bit form mode A,B,C,D.
// - modes A and C switch at the trip threshold; bus and memory off on backup.
// - modes A and C keep the bus on while main supply is above trip threshold.
// - mode C keeps the freq_or_irq_output output alive on backup, mode A does not.
// - mode B switches below backup voltage; bus runs if vbat>vdd>reset.
// - mode D uses legacy switchover; bus only above max(reset, vbat).
// - after power-up mode B, with legacy switchover, is the default.
// - standard mode leaves only timekeeping powered on backup.
//
// file: supply selection and bus gating from the two mode bits
// assumes comparator inputs are asynchronous, mode bits from config logic
`timescale 1ns/1ps
`include "bkg_consts.svh"
module bkg_gate (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic backup_bus_disable_i,
    input wire logic switchover_select_i,
    input wire logic cfg_valid_i,
    input wire logic vdd_below_reset_i,
    input wire logic vdd_below_trip_i,
    input wire logic vdd_below_vbat_i,
    output logic on_backup_o,
    output logic bus_enable_o,
    output logic mem_enable_o,
    output logic freq_or_irq_enable_o,
    output logic low_voltage_reset_o,
    output logic [1:0] mode_o
);
    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        bkg_pkg::bkg_state_t state;
        logic bus_dis;
        logic sw_sel;
        logic on_backup;
        logic bus_en;
        logic mem_en;
        logic fi_en;
        logic low_voltage_reset;
        logic [1:0] mode;
    } bkg_gate_st_t;
    bkg_gate_st_t st_ff;
    bkg_gate_st_t nxt_st;
    logic [2:0] cmp_sync;
    logic below_rst;
    logic below_trip;
    logic below_vbat;

    function automatic logic [1:0] mode_code(input logic dis,
                                             input logic sel);
        mode_code = {dis, sel};
    endfunction : mode_code

    ////////////////////////////////////////////////////////////////////
    bkg_sync #(
        .WIDTH(3)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({vdd_below_reset_i, vdd_below_trip_i, vdd_below_vbat_i}),
        .sync_o(cmp_sync)
    );
    assign below_rst = cmp_sync[2];
    assign below_trip = cmp_sync[1];
    assign below_vbat = cmp_sync[0];

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic legacy;
        logic go_backup;
        logic [1:0] m;
        legacy = 1'b0;
        go_backup = 1'b0;
        m = 2'h0;
        nxt_st = st_ff;
        if (cfg_valid_i) begin
            nxt_st.bus_dis = backup_bus_disable_i;
            nxt_st.sw_sel = switchover_select_i;
        end
        m = mode_code(nxt_st.bus_dis, nxt_st.sw_sel);
        legacy = nxt_st.sw_sel;
        if (legacy) begin
            go_backup = below_vbat;
        end else begin
            go_backup = below_trip;
        end
        nxt_st.mode = m;
        nxt_st.on_backup = go_backup;
        nxt_st.low_voltage_reset = below_rst;
        unique case (st_ff.state)
            bkg_pkg::BKG_ON_MAIN: begin
                if (below_rst) begin
                    nxt_st.state = bkg_pkg::BKG_IN_RESET;
                end else if (go_backup) begin
                    nxt_st.state = bkg_pkg::BKG_ON_BACKUP;
                end
            end
            bkg_pkg::BKG_ON_BACKUP: begin
                if (below_rst) begin
                    nxt_st.state = bkg_pkg::BKG_IN_RESET;
                end else if (!go_backup) begin
                    nxt_st.state = bkg_pkg::BKG_ON_MAIN;
                end
            end
            bkg_pkg::BKG_IN_RESET: begin
                if (!below_rst) begin
                    nxt_st.state = go_backup ? bkg_pkg::BKG_ON_BACKUP
                                             : bkg_pkg::BKG_ON_MAIN;
                end
            end
            default: begin
                nxt_st.state = bkg_pkg::BKG_IN_RESET;
            end
        endcase
        if (below_rst) begin
            nxt_st.bus_en = 1'b0;
        end else begin
            unique case (m)
                `BKG_MODE_A, `BKG_MODE_C: begin
                    nxt_st.bus_en = !go_backup;
                end
                `BKG_MODE_B: begin
                    nxt_st.bus_en = 1'b1;
                end
                `BKG_MODE_D: begin
                    nxt_st.bus_en = !below_vbat;
                end
            endcase
        end
        nxt_st.mem_en = nxt_st.bus_en;
        if (!go_backup) begin
            nxt_st.fi_en = 1'b1;
        end else begin
            nxt_st.fi_en = (m != `BKG_MODE_A);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff.state <= bkg_pkg::BKG_IN_RESET;
            st_ff.bus_dis <= `BKG_RST_DIS_BIT;
            st_ff.sw_sel <= `BKG_RST_SW_SEL;
            st_ff.on_backup <= 1'b0;
            st_ff.bus_en <= 1'b0;
            st_ff.mem_en <= 1'b0;
            st_ff.fi_en <= 1'b0;
            st_ff.low_voltage_reset <= 1'b1;
            st_ff.mode <= `BKG_MODE_B;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign on_backup_o = st_ff.on_backup;
    assign bus_enable_o = st_ff.bus_en;
    assign mem_enable_o = st_ff.mem_en;
    assign freq_or_irq_enable_o = st_ff.fi_en;
    assign low_voltage_reset_o = st_ff.low_voltage_reset;
    assign mode_o = st_ff.mode;
endmodule : bkg_gate

// [bench/bkg_host_model.sv]
// serial-bus host beside the block: pulls lines, counts served cycles
// assumes bus_enable_i tells whether the device answers
`timescale 1ns/1ps
module bkg_host_model (
    input wire logic ref_clk_i,
    input wire logic bus_enable_i,
    input wire logic [1:0] mode_i,
    output logic pullup_to_backup_o,
    output logic [15:0] acked_o
);
    // pull-ups go to the backup supply in mode b
    assign pullup_to_backup_o = (mode_i == 2'h1);
    initial acked_o = 16'h0000;
    always @(posedge ref_clk_i) if (bus_enable_i) acked_o <= acked_o + 16'h1;
endmodule : bkg_host_model

// [bench/bkg_gate_monitor.sv]
// port assertions for the backup bus gating block
// assumes bound to every bkg_gate, one clock
`timescale 1ns/1ps
module bkg_gate_chk (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic backup_bus_disable_i,
    input wire logic switchover_select_i,
    input wire logic cfg_valid_i,
    input wire logic vdd_below_reset_i,
    input wire logic vdd_below_trip_i,
    input wire logic vdd_below_vbat_i,
    input wire logic on_backup_o,
    input wire logic bus_enable_o,
    input wire logic mem_enable_o,
    input wire logic freq_or_irq_enable_o,
    input wire logic low_voltage_reset_o,
    input wire logic [1:0] mode_o
);
    logic [2:0] up_ff;
    wire up = (up_ff == 3'h4);
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
        if (!rst_n_i) up_ff <= 3'h0;
        else if (!up) up_ff <= up_ff + 3'h1;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_lvr_sync: assert property (
        up |-> low_voltage_reset_o == $past(vdd_below_reset_i, 3))
        else $error("lvr lag wrong");
    chk_lvr_bus: assert property (low_voltage_reset_o |-> !bus_enable_o)
        else $error("bus on in reset");
    chk_mem_bus: assert property (mem_enable_o == bus_enable_o)
        else $error("mem differs from bus");
    chk_mode_decode: assert property (up && cfg_valid_i |=> mode_o ==
        {$past(backup_bus_disable_i), $past(switchover_select_i)})
        else $error("mode decode wrong");
    chk_backup_select: assert property (up && $stable(mode_o) |->
        on_backup_o == (mode_o[0] ? $past(vdd_below_vbat_i, 3)
        : $past(vdd_below_trip_i, 3))) else $error("switchover wrong");
    chk_ac_bus: assert property (up && $stable(mode_o) && !mode_o[0] |->
        bus_enable_o == (!on_backup_o && !low_voltage_reset_o))
        else $error("a/c bus wrong");
    chk_bd_bus: assert property (up && $stable(mode_o) && mode_o[0] |->
        bus_enable_o == (!low_voltage_reset_o &&
        !(mode_o[1] && $past(vdd_below_vbat_i, 3)))) else $error("b/d bus");
    chk_freq_backup: assert property (up && $stable(mode_o) && on_backup_o
        && !mode_o[0] |-> freq_or_irq_enable_o == mode_o[1])
        else $error("freq on backup wrong");
endmodule : bkg_gate_chk
bind bkg_gate bkg_gate_chk u_chk (.*);

// [bench/bkg_gate_tb.sv]
// self-checking bench for the backup bus gating block
// assumes checker bound in, host model beside
`timescale 1ns/1ps
module bkg_gate_tb;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, cfg_valid_i = 1'b0;
    logic backup_bus_disable_i = 1'b0, switchover_select_i = 1'b0;
    logic vdd_below_reset_i = 1'b0, vdd_below_trip_i = 1'b0;
    logic vdd_below_vbat_i = 1'b0, chk_req = 1'b0;
    logic on_backup_o, bus_enable_o, mem_enable_o;
    logic freq_or_irq_enable_o, low_voltage_reset_o;
    logic [1:0] mode_o, cur = 2'h1;
    logic [6:0] q[$];
    int n_fail = 0, tests_run = 0, cyc = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    bkg_gate u_dut (.*);
    bkg_host_model u_host (.ref_clk_i, .bus_enable_i(bus_enable_o),
        .mode_i(mode_o), .pullup_to_backup_o(), .acked_o());
    task automatic check(input logic [6:0] got, input logic [6:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %b exp %b", $time, got, exp);
        end
    endtask : check
    function automatic logic [6:0] exp_of(input logic [1:0] m, input logic r,
        input logic t, input logic v);
        logic bk, bus;
        bk = m[0] ? v : t;
        bus = !r && ((m == 2'h3) ? !v : (m[0] || !bk));
        return {bk, bus, bus, r, bk & (m != 2'h0), m};
    endfunction : exp_of
    task automatic note(input logic [6:0] e, input int wait_n);
        q.push_back(e);
        repeat (wait_n) @(posedge ref_clk_i);
        #5 chk_req = 1'b1;
        @(posedge ref_clk_i);
        #5 chk_req = 1'b0;
    endtask : note
    task automatic apply(input logic [5:0] w);
        @(posedge ref_clk_i);
        #5 {cfg_valid_i, backup_bus_disable_i, switchover_select_i,
            vdd_below_reset_i, vdd_below_trip_i, vdd_below_vbat_i} = w;
        if (w[5]) cur = w[4:3];
        note(exp_of(cur, w[2], w[1], w[0]), 4);
    endtask : apply
    task automatic final_report();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    always @(negedge ref_clk_i) if (chk_req) check({on_backup_o, bus_enable_o,
        mem_enable_o, low_voltage_reset_o, on_backup_o & freq_or_irq_enable_o,
        mode_o}, q.pop_front());
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 2000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        void'($urandom(18296));
        note(7'h09, 10);
        repeat (9) @(posedge ref_clk_i);
        #5 rst_n_i = 1'b1;
        for (int i = 0; i < 32; i++) apply({1'b1, 5'(i)});
        for (int i = 0; i < 64; i++) apply(6'($urandom));
        final_report();
    end
endmodule : bkg_gate_tb
